// File: rtl/tlbc_pkg.sv
package tlbc_pkg;

  // Field widths
  localparam int TLBC_VPN_W = 20;
  localparam int TLBC_PID_MAX_W = 14;
  localparam int TLBC_PID_MIN_W = 8;
  localparam int TLBC_WAY_MAX = 16;
  localparam int TLBC_WAY_FIELD_W = 4;

  // Auxiliary control word layout
  localparam int TLBC_D_BIT = 0;
  localparam int TLBC_RIGHTS_BIT = 1;
  localparam int TLBC_BAD_BIT = 2;
  localparam int TLBC_DOUBLE_BIT = 3;
  localparam int TLBC_PID_LSB = 4;
  localparam int TLBC_WE_BIT = 18;
  localparam int TLBC_RD_BIT = 19;
  localparam int TLBC_WAY_LSB = 20;
  localparam int TLBC_SOFT_ERR_BIT = 24;

  // Page address word layout
  localparam int TLBC_VPN_LSB = 2;

  // Value after reset and the mask that clears address bit 31
  localparam logic [31:0] TLBC_RESET_WORD = 32'h0000_0000;
  localparam logic [31:0] TLBC_ADDR_BIT31_MASK = 32'h7fff_ffff;

  // Cycles from a read trigger to loaded fields
  localparam int TLBC_READ_CYCLES = 1;

  // Control register selector
  typedef enum logic [1:0] {
    TLBC_SEL_MISC  = 2'h0,
    TLBC_SEL_FAULT = 2'h1,
    TLBC_SEL_ENTRY = 2'h2,
    TLBC_SEL_PAGE  = 2'h3
  } tlbc_sel_e;

  // Exception causes reported by the exception logic
  typedef enum logic [3:0] {
    TLBC_EXC_OTHER       = 4'h0,
    TLBC_EXC_FMISS_INST  = 4'h1,
    TLBC_EXC_FMISS_DATA  = 4'h2,
    TLBC_EXC_DMISS_INST  = 4'h3,
    TLBC_EXC_DMISS_DATA  = 4'h4,
    TLBC_EXC_PROT_EXEC   = 4'h5,
    TLBC_EXC_PROT_READ   = 4'h6,
    TLBC_EXC_PROT_WRITE  = 4'h7,
    TLBC_EXC_SUPER_INST  = 4'h8,
    TLBC_EXC_SUPER_DATA  = 4'h9,
    TLBC_EXC_MISAL_DATA  = 4'ha,
    TLBC_EXC_MISAL_DEST  = 4'hb,
    TLBC_EXC_BREAK       = 4'hc
  } tlbc_cause_e;

  // One general exception event
  typedef struct packed {
    tlbc_cause_e cause;
    logic active;
    logic addr_valid;
    logic addr_is_data;
    logic [31:0] addr;
    logic [TLBC_VPN_W-1:0] virtual_page_number;
  } tlbc_exc_s;

  // One TLB entry
  typedef struct packed {
    logic [TLBC_VPN_W-1:0] virtual_page_number;
    logic [TLBC_PID_MAX_W-1:0] process_tag;
    logic [31:0] value;
  } tlbc_entry_s;

endpackage

// File: rtl/tlbc_entry_store.sv
module tlbc_entry_store import tlbc_pkg::*; #(
  parameter int WAYS = 16,
  parameter int LINE_W = 4
) (
  // Clock
  input wire logic clk_i,
  // Write port
  input wire logic wr_en_i,
  input wire logic [TLBC_WAY_FIELD_W-1:0] wr_way_i,
  input wire logic [LINE_W-1:0] wr_line_i,
  input wire tlbc_entry_s wr_entry_i,
  // Read port, combinational
  input wire logic [TLBC_WAY_FIELD_W-1:0] rd_way_i,
  input wire logic [LINE_W-1:0] rd_line_i,
  output tlbc_entry_s rd_entry_o,
  output logic rd_err_o
);

  localparam int DEPTH = WAYS << LINE_W;
  localparam int IDX_W = TLBC_WAY_FIELD_W + LINE_W;

  tlbc_entry_s mem [DEPTH];
  logic par_mem [DEPTH];
  logic [IDX_W-1:0] wr_idx;
  logic [IDX_W-1:0] rd_idx;

  // Way selects the set, line selects the row
  assign wr_idx = {wr_way_i, wr_line_i};
  assign rd_idx = {rd_way_i, rd_line_i};

  // Entry array with a check bit per entry
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_idx] <= wr_entry_i;
      par_mem[wr_idx] <= ^wr_entry_i;
    end
  end

  // Check bit disagreement marks a soft error
  assign rd_entry_o = mem[rd_idx];
  assign rd_err_o = (^mem[rd_idx]) != par_mem[rd_idx];

endmodule

// File: rtl/tlbc_control.sv
// Contract
// R1: Read trigger loads tag, process tag and entry value from the chosen entry.
// R2: Changing page number, way or process tag alone loads nothing.
// R3: Entry-value write also writes a TLB entry only when write-through is one.
// R4: Permission violation, or miss outside an active exception, sets write-through.
// R5: Every software TLB write advances the way field.
// R6: Way count is a parameter up to 16; unused way bits written zero.
// R7: Process tag width is 8 to 14 bits; unused upper bits written zero.
// R8: Process tag from the read entry beats the value in the triggering write.
// R9: Software loads the process tag on switches and before each TLB write.
// R10: Each general exception sets double-miss flag on double miss, else clears.
// R11: Each general exception sets bad-address flag for four causes, else clears.
// R12: Each general exception sets permission flag on violation, else clears.
// R13: Access-type flag set for data causes, cleared for other non-break exceptions.
// R14: Read trigger is write-only bit 19; write-through is bit 18.
// R15: A software TLB read meeting an ECC error sets the soft-error flag.
// R16: Some exceptions capture their byte address in the read-only fault register.
// R17: With MMU or MPU the fault address is full 32 bits, virtual with MMU.
// R18: Narrow space without units reads high bits zero; no MMU clears data bit 31.
// R19: TLB write stores entry value, page number and process tag at line/way.
// R20: Page number loads on fast miss, violation or read, not when exception active.
// R21: Reads of loaded fields wait until a triggered TLB read has completed.
module tlbc_control import tlbc_pkg::*; #(
  parameter int WAYS = 16,
  parameter int LINE_W = 4,
  parameter int PID_W = 14,
  parameter int ADDR_W = 32,
  parameter bit HAS_MMU = 1'b1,
  parameter bit HAS_MPU = 1'b0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control register access
  input wire logic ctl_wr_i,
  input wire logic ctl_rd_i,
  input wire tlbc_sel_e ctl_sel_i,
  input wire logic [31:0] ctl_wdata_i,
  output logic [31:0] ctl_rdata_o,
  output logic ctl_rvalid_o,
  output logic ctl_ready_o,
  // Exception logic
  input wire logic exc_valid_i,
  input wire tlbc_exc_s exc_i,
  // Configuration
  input wire logic ecc_enable_i,
  // State seen by the translation logic
  output logic [PID_W-1:0] process_tag_o,
  output logic [TLBC_VPN_W-1:0] virtual_page_number_o,
  output logic write_through_o
);

  localparam int WAY_W = (WAYS > 1) ? $clog2(WAYS) : 1;

  typedef enum logic [0:0] {
    TLBC_ST_IDLE = 1'b0,
    TLBC_ST_READ = 1'b1
  } tlbc_state_e;

  tlbc_state_e state_reg;
  logic [TLBC_VPN_W-1:0] virtual_page_number_reg;
  logic [PID_W-1:0] process_tag_reg;
  logic [TLBC_WAY_FIELD_W-1:0] way_reg;
  logic write_through_reg;
  logic ecc_soft_error_flag_reg;
  logic double_miss_flag_reg;
  logic bad_addr_flag_reg;
  logic access_rights_fault_flag_reg;
  logic data_access_flag_reg;
  logic [31:0] entry_value_reg;
  logic [31:0] exception_address_reg;
  logic [31:0] ctl_rdata_reg;
  logic ctl_rvalid_reg;
  logic ctl_ready_reg;

  logic take_wr;
  logic take_rd;
  logic misc_wr;
  logic read_trig;
  logic tlb_wr;
  logic hw_vpn_load;
  logic [TLBC_WAY_FIELD_W-1:0] way_next;
  tlbc_entry_s wr_entry;
  tlbc_entry_s rd_entry;
  logic rd_err;
  logic [31:0] fault_addr_next;

  // Causes that flag a bad virtual address
  function automatic logic is_bad_cause(input tlbc_cause_e c);
    return c == TLBC_EXC_SUPER_INST || c == TLBC_EXC_SUPER_DATA ||
           c == TLBC_EXC_MISAL_DATA || c == TLBC_EXC_MISAL_DEST;
  endfunction

  // Causes that belong to a data access
  function automatic logic is_data_cause(input tlbc_cause_e c);
    return c == TLBC_EXC_FMISS_DATA || c == TLBC_EXC_DMISS_DATA ||
           c == TLBC_EXC_PROT_READ || c == TLBC_EXC_PROT_WRITE ||
           c == TLBC_EXC_MISAL_DATA || c == TLBC_EXC_SUPER_DATA;
  endfunction

  // Permission violation of any kind
  function automatic logic is_prot_cause(input tlbc_cause_e c);
    return c == TLBC_EXC_PROT_EXEC || c == TLBC_EXC_PROT_READ ||
           c == TLBC_EXC_PROT_WRITE;
  endfunction

  // Fast or double miss of either kind
  function automatic logic is_miss_cause(input tlbc_cause_e c);
    return c == TLBC_EXC_FMISS_INST || c == TLBC_EXC_FMISS_DATA ||
           c == TLBC_EXC_DMISS_INST || c == TLBC_EXC_DMISS_DATA;
  endfunction

  // Request qualification; nothing is taken while a read is loading
  assign take_wr = ctl_wr_i && (state_reg == TLBC_ST_IDLE); // [R21]
  assign take_rd = ctl_rd_i && (state_reg == TLBC_ST_IDLE); // [R21]
  assign misc_wr = take_wr && (ctl_sel_i == TLBC_SEL_MISC);
  assign read_trig = misc_wr && ctl_wdata_i[TLBC_RD_BIT]; // [R14]
  assign tlb_wr = take_wr && (ctl_sel_i == TLBC_SEL_ENTRY) && write_through_reg; // [R3]

  // Fast miss and permission violation reload the page number
  assign hw_vpn_load = exc_valid_i && !exc_i.active &&
                       (exc_i.cause == TLBC_EXC_FMISS_INST ||
                        exc_i.cause == TLBC_EXC_FMISS_DATA ||
                        is_prot_cause(exc_i.cause)); // [R20]

  // Way wraps at the configured number of ways
  always_comb begin
    if (32'(way_reg) + 32'd1 >= 32'(WAYS)) begin
      way_next = '0;
    end else begin
      way_next = way_reg + 4'h1; // [R5]
    end
  end

  // Entry written from entry value, page number and process tag
  always_comb begin
    wr_entry = '0;
    wr_entry.virtual_page_number = virtual_page_number_reg;
    wr_entry.process_tag[PID_W-1:0] = process_tag_reg;
    wr_entry.value = ctl_wdata_i; // [R19]
  end

  // Entry storage, selected by line and way
  tlbc_entry_store #(
    .WAYS(WAYS),
    .LINE_W(LINE_W)
  ) u_store (
    .clk_i(clk_i),
    .wr_en_i(tlb_wr),
    .wr_way_i(way_reg),
    .wr_line_i(virtual_page_number_reg[LINE_W-1:0]),
    .wr_entry_i(wr_entry),
    .rd_way_i(way_reg),
    .rd_line_i(virtual_page_number_reg[LINE_W-1:0]),
    .rd_entry_o(rd_entry),
    .rd_err_o(rd_err)
  );

  // Read sequencer: one cycle of load after the trigger
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= TLBC_ST_IDLE;
    end else begin
      case (state_reg)
        TLBC_ST_IDLE: begin
          if (read_trig) begin
            state_reg <= TLBC_ST_READ; // [R1]
          end
        end
        TLBC_ST_READ: begin
          state_reg <= TLBC_ST_IDLE;
        end
        default: begin
          state_reg <= TLBC_ST_IDLE;
        end
      endcase
    end
  end

  // Ready drops for the load cycle that follows a read trigger
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_ready_reg <= 1'b1;
    end else begin
      ctl_ready_reg <= !read_trig; // [R21]
    end
  end

  // Page number: read load, then exception, then software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      virtual_page_number_reg <= '0;
    end else if (state_reg == TLBC_ST_READ) begin
      virtual_page_number_reg <= {rd_entry.virtual_page_number[TLBC_VPN_W-1:LINE_W],
                                  virtual_page_number_reg[LINE_W-1:0]}; // [R1] [R20]
    end else if (hw_vpn_load) begin
      virtual_page_number_reg <= exc_i.virtual_page_number; // [R20]
    end else if (take_wr && ctl_sel_i == TLBC_SEL_PAGE) begin
      virtual_page_number_reg <= ctl_wdata_i[TLBC_VPN_LSB +: TLBC_VPN_W]; // [R2]
    end
  end

  // Process tag; loaded entry wins over the triggering write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      process_tag_reg <= '0;
    end else if (state_reg == TLBC_ST_READ) begin
      process_tag_reg <= rd_entry.process_tag[PID_W-1:0]; // [R1] [R8]
    end else if (misc_wr) begin
      process_tag_reg <= ctl_wdata_i[TLBC_PID_LSB +: PID_W]; // [R7] [R2]
    end
  end

  // Way field, advanced by every TLB write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      way_reg <= '0;
    end else if (tlb_wr) begin
      way_reg <= way_next; // [R5]
    end else if (misc_wr) begin
      way_reg <= TLBC_WAY_FIELD_W'(ctl_wdata_i[TLBC_WAY_LSB +: WAY_W]); // [R6]
    end
  end

  // Write-through flag; hardware set beats a software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      write_through_reg <= 1'b0;
    end else if (exc_valid_i && (is_prot_cause(exc_i.cause) ||
                 (is_miss_cause(exc_i.cause) && !exc_i.active))) begin
      write_through_reg <= 1'b1; // [R4]
    end else if (misc_wr) begin
      write_through_reg <= ctl_wdata_i[TLBC_WE_BIT]; // [R14]
    end
  end

  // Soft-error flag; a failed read beats a software write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ecc_soft_error_flag_reg <= 1'b0;
    end else if (state_reg == TLBC_ST_READ && rd_err && ecc_enable_i) begin
      ecc_soft_error_flag_reg <= 1'b1; // [R15]
    end else if (misc_wr) begin
      ecc_soft_error_flag_reg <= ctl_wdata_i[TLBC_SOFT_ERR_BIT];
    end
  end

  // Cause flags, rewritten on every general exception; data-access flag kept on break
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      double_miss_flag_reg <= 1'b0;
      bad_addr_flag_reg <= 1'b0;
      access_rights_fault_flag_reg <= 1'b0;
      data_access_flag_reg <= 1'b0;
    end else if (exc_valid_i) begin
      double_miss_flag_reg <= exc_i.cause == TLBC_EXC_DMISS_INST ||
                              exc_i.cause == TLBC_EXC_DMISS_DATA; // [R10]
      bad_addr_flag_reg <= is_bad_cause(exc_i.cause); // [R11]
      access_rights_fault_flag_reg <= is_prot_cause(exc_i.cause); // [R12]
      if (exc_i.cause != TLBC_EXC_BREAK) begin
        data_access_flag_reg <= is_data_cause(exc_i.cause); // [R13]
      end
    end
  end

  // Entry value: loaded by a read, else written by software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      entry_value_reg <= TLBC_RESET_WORD;
    end else if (state_reg == TLBC_ST_READ) begin
      entry_value_reg <= rd_entry.value; // [R1]
    end else if (take_wr && ctl_sel_i == TLBC_SEL_ENTRY) begin
      entry_value_reg <= ctl_wdata_i; // [R3]
    end
  end

  // Fault address shaped by the configuration
  always_comb begin
    fault_addr_next = exc_i.addr; // [R17]
    if (!HAS_MMU && exc_i.addr_is_data) begin
      fault_addr_next = fault_addr_next & TLBC_ADDR_BIT31_MASK; // [R18]
    end
    if (!HAS_MMU && !HAS_MPU && ADDR_W < 32) begin
      fault_addr_next = fault_addr_next & ((32'h1 << ADDR_W) - 32'h1); // [R18]
    end
  end

  // Fault address capture, read-only to software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      exception_address_reg <= TLBC_RESET_WORD;
    end else if (exc_valid_i && exc_i.addr_valid) begin
      exception_address_reg <= fault_addr_next; // [R16]
    end
  end

  // Read answer one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_rdata_reg <= TLBC_RESET_WORD;
      ctl_rvalid_reg <= 1'b0;
    end else begin
      ctl_rvalid_reg <= take_rd; // [R21]
      if (take_rd) begin
        ctl_rdata_reg <= TLBC_RESET_WORD;
        case (ctl_sel_i)
          TLBC_SEL_MISC: begin
            ctl_rdata_reg[TLBC_D_BIT] <= data_access_flag_reg;
            ctl_rdata_reg[TLBC_RIGHTS_BIT] <= access_rights_fault_flag_reg;
            ctl_rdata_reg[TLBC_BAD_BIT] <= bad_addr_flag_reg;
            ctl_rdata_reg[TLBC_DOUBLE_BIT] <= double_miss_flag_reg;
            ctl_rdata_reg[TLBC_PID_LSB +: PID_W] <= process_tag_reg;
            ctl_rdata_reg[TLBC_WE_BIT] <= write_through_reg;
            ctl_rdata_reg[TLBC_WAY_LSB +: TLBC_WAY_FIELD_W] <= way_reg;
            ctl_rdata_reg[TLBC_SOFT_ERR_BIT] <= ecc_soft_error_flag_reg;
          end
          TLBC_SEL_FAULT: begin
            ctl_rdata_reg <= exception_address_reg;
          end
          TLBC_SEL_ENTRY: begin
            ctl_rdata_reg <= entry_value_reg;
          end
          TLBC_SEL_PAGE: begin
            ctl_rdata_reg[TLBC_VPN_LSB +: TLBC_VPN_W] <= virtual_page_number_reg;
          end
          default: begin
            ctl_rdata_reg <= TLBC_RESET_WORD;
          end
        endcase
      end
    end
  end

  // Outputs straight from flip-flops
  assign ctl_rdata_o = ctl_rdata_reg;
  assign ctl_rvalid_o = ctl_rvalid_reg;
  assign ctl_ready_o = ctl_ready_reg;
  assign process_tag_o = process_tag_reg;
  assign virtual_page_number_o = virtual_page_number_reg;
  assign write_through_o = write_through_reg;

endmodule

// File: bench/tlbc_control_props.sv
module tlbc_control_props import tlbc_pkg::*; #(
  parameter int PID_W = 14
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register access
  input wire logic ctl_wr_i,
  input wire logic ctl_rd_i,
  input wire tlbc_sel_e ctl_sel_i,
  input wire logic [31:0] ctl_wdata_i,
  input wire logic [31:0] ctl_rdata_o,
  input wire logic ctl_rvalid_o,
  input wire logic ctl_ready_o,
  // Exceptions and state
  input wire logic exc_valid_i,
  input wire tlbc_exc_s exc_i,
  input wire logic [PID_W-1:0] process_tag_o,
  input wire logic [TLBC_VPN_W-1:0] virtual_page_number_o,
  input wire logic write_through_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Decoded requests and events
  logic take_w, trig_w, prot_w, miss_w, fast_w, we_w;
  logic [PID_W-1:0] pid_w;
  logic [TLBC_VPN_W-1:0] vpn_w;
  assign take_w = ctl_wr_i && ctl_ready_o && ctl_sel_i == TLBC_SEL_MISC;
  assign trig_w = take_w && ctl_wdata_i[TLBC_RD_BIT];
  assign prot_w = exc_valid_i && exc_i.cause inside {TLBC_EXC_PROT_EXEC, TLBC_EXC_PROT_READ,
    TLBC_EXC_PROT_WRITE};
  assign fast_w = exc_valid_i && exc_i.cause inside {TLBC_EXC_FMISS_INST, TLBC_EXC_FMISS_DATA};
  assign miss_w = fast_w || (exc_valid_i && exc_i.cause inside {TLBC_EXC_DMISS_INST,
    TLBC_EXC_DMISS_DATA});
  assign we_w = ctl_wdata_i[TLBC_WE_BIT];
  assign pid_w = ctl_wdata_i[TLBC_PID_LSB +: PID_W];
  assign vpn_w = exc_i.virtual_page_number;

  read_answer_a: assert property (ctl_rd_i && ctl_ready_o |=> ctl_rvalid_o)
    else $error("read not answered");
  trig_stall_a: assert property (trig_w |=> !ctl_ready_o ##1 ctl_ready_o)
    else $error("read trigger stall wrong");
  we_hw_set_a: assert property (prot_w || (miss_w && !exc_i.active) |=> write_through_o)
    else $error("write-through not set");
  we_sw_a: assert property (take_w && !exc_valid_i |=> write_through_o == $past(we_w))
    else $error("write-through write lost");
  pid_sw_a: assert property (take_w && !trig_w |=> process_tag_o == $past(pid_w))
    else $error("process tag write lost");
  vpn_keep_a: assert property (exc_valid_i && exc_i.active && ctl_ready_o && !ctl_wr_i
    |=> $stable(virtual_page_number_o)) else $error("page number changed");
  vpn_load_a: assert property ((fast_w || prot_w) && !exc_i.active
    |=> virtual_page_number_o == $past(vpn_w)) else $error("page number not loaded");
  rd_bit_zero_a: assert property (ctl_rvalid_o && $past(ctl_sel_i) == TLBC_SEL_MISC
    |-> !ctl_rdata_o[TLBC_RD_BIT]) else $error("read trigger reads back");
  page_hold_a: assert property (ctl_wr_i && ctl_ready_o && ctl_sel_i == TLBC_SEL_PAGE
    |=> $stable(process_tag_o)) else $error("process tag changed");
endmodule

bind tlbc_control tlbc_control_props #(.PID_W(PID_W)) tlbc_control_props_inst (
  .clk_i(clk_i), .rst_i(rst_i), .ctl_wr_i(ctl_wr_i), .ctl_rd_i(ctl_rd_i),
  .ctl_sel_i(ctl_sel_i), .ctl_wdata_i(ctl_wdata_i), .ctl_rdata_o(ctl_rdata_o),
  .ctl_rvalid_o(ctl_rvalid_o), .ctl_ready_o(ctl_ready_o), .exc_valid_i(exc_valid_i),
  .exc_i(exc_i), .process_tag_o(process_tag_o), .virtual_page_number_o(virtual_page_number_o),
  .write_through_o(write_through_o));

// File: bench/tlbc_exc_model.sv
module tlbc_exc_model import tlbc_pkg::*; (
  // Clock
  input wire logic clk_i,
  // Exception event
  output logic exc_valid_o,
  output tlbc_exc_s exc_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle after reset
  initial begin
    exc_valid_o = 1'b0;
    exc_o = '0;
  end

  // One-cycle exception event; address and page number are scrambled once it is gone
  task automatic raise(input tlbc_cause_e c, input logic act, input logic isd,
                       input logic [31:0] a);
    @(posedge clk_i);
    exc_valid_o <= 1'b1;
    exc_o <= '{cause: c, active: act, addr_valid: 1'b1, addr_is_data: isd, addr: a,
               virtual_page_number: a[31:12]};
    @(posedge clk_i);
    exc_valid_o <= 1'b0;
    exc_o.addr <= ~a;
    exc_o.virtual_page_number <= ~a[31:12];
  endtask
endmodule

// File: bench/tb_tlbc_control.sv
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end

module tb_tlbc_control import tlbc_pkg::*; ();
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_i, rst_i, ctl_wr_i, ctl_rd_i, exc_valid_i, ctl_rvalid_o, ctl_ready_o;
  logic write_through_o, prot, fmiss, dmiss, bad, d, dprev;
  tlbc_sel_e ctl_sel_i;
  tlbc_cause_e c;
  tlbc_exc_s exc_i;
  logic [31:0] ctl_wdata_i, ctl_rdata_o, q, a, exp_page;
  logic [13:0] process_tag_o;
  logic [19:0] virtual_page_number_o;
  int n_errors, total_checks;

  // Device and exception source
  tlbc_control tlbc_control_inst (.clk_i(clk_i), .rst_i(rst_i), .ctl_wr_i(ctl_wr_i),
    .ctl_rd_i(ctl_rd_i), .ctl_sel_i(ctl_sel_i), .ctl_wdata_i(ctl_wdata_i),
    .ctl_rdata_o(ctl_rdata_o), .ctl_rvalid_o(ctl_rvalid_o), .ctl_ready_o(ctl_ready_o),
    .exc_valid_i(exc_valid_i), .exc_i(exc_i), .ecc_enable_i(1'b1),
    .process_tag_o(process_tag_o), .virtual_page_number_o(virtual_page_number_o),
    .write_through_o(write_through_o));
  tlbc_exc_model tlbc_exc_model_inst (.clk_i(clk_i), .exc_valid_o(exc_valid_i), .exc_o(exc_i));

  // Clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Final report
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One register access, held until taken; reads return the answer word
  task automatic acc(input logic w, input tlbc_sel_e s, input logic [31:0] dt,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    ctl_wr_i <= w;
    ctl_rd_i <= !w;
    ctl_sel_i <= s;
    ctl_wdata_i <= dt;
    @(negedge clk_i);
    while (ctl_ready_o !== 1'b1 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 20) begin
      n_errors++;
      print_verdict();
    end
    @(posedge clk_i);
    ctl_wr_i <= 1'b0;
    ctl_rd_i <= 1'b0;
    ctl_wdata_i <= ~dt;
    @(negedge clk_i);
    r = ctl_rdata_o;
    if (!w) `CHK(ctl_rvalid_o, 1'b1)
  endtask

  // Main sequence
  initial begin
    rst_i = 1'b1;
    ctl_wr_i = 1'b0;
    ctl_rd_i = 1'b0;
    ctl_sel_i = TLBC_SEL_MISC;
    ctl_wdata_i = 32'h0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      acc(1'b0, tlbc_sel_e'(s[1:0]), 32'h0, q);
      `CHK(q, TLBC_RESET_WORD)
    end
    `CHK({process_tag_o, virtual_page_number_o, write_through_o}, 35'h0)
    $display("test reset done");
    acc(1'b1, TLBC_SEL_MISC, 32'h00f4_0050, q);
    acc(1'b1, TLBC_SEL_PAGE, 32'h0004_8d14, q);
    acc(1'b1, TLBC_SEL_ENTRY, 32'ha5a5_0001, q);
    acc(1'b1, TLBC_SEL_ENTRY, 32'ha5a5_0002, q);
    acc(1'b0, TLBC_SEL_MISC, 32'h0, q);
    `CHK(q, 32'h0014_0050)
    acc(1'b1, TLBC_SEL_MISC, 32'h00f0_0050, q);
    acc(1'b1, TLBC_SEL_ENTRY, 32'h0000_dead, q);
    acc(1'b0, TLBC_SEL_MISC, 32'h0, q);
    `CHK(q, 32'h00f0_0050)
    $display("test tlb write done");
    acc(1'b1, TLBC_SEL_PAGE, 32'h0015_0c94, q);
    acc(1'b0, TLBC_SEL_ENTRY, 32'h0, q);
    `CHK(q, 32'h0000_dead)
    acc(1'b1, TLBC_SEL_MISC, 32'h00f8_3ff0, q);
    acc(1'b0, TLBC_SEL_ENTRY, 32'h0, q);
    `CHK(q, 32'ha5a5_0001)
    acc(1'b0, TLBC_SEL_PAGE, 32'h0, q);
    `CHK(q, 32'h0004_8d14)
    acc(1'b0, TLBC_SEL_MISC, 32'h0, q);
    `CHK(q, 32'h00f0_0050)
    $display("test tlb read done");
    exp_page = 32'h0004_8d14;
    dprev = 1'b0;
    for (int i = 0; i < 13; i++) begin
      c = tlbc_cause_e'(i[3:0]);
      prot = c inside {TLBC_EXC_PROT_EXEC, TLBC_EXC_PROT_READ, TLBC_EXC_PROT_WRITE};
      fmiss = c inside {TLBC_EXC_FMISS_INST, TLBC_EXC_FMISS_DATA};
      dmiss = c inside {TLBC_EXC_DMISS_INST, TLBC_EXC_DMISS_DATA};
      bad = c inside {TLBC_EXC_SUPER_INST, TLBC_EXC_SUPER_DATA, TLBC_EXC_MISAL_DATA,
        TLBC_EXC_MISAL_DEST};
      d = c inside {TLBC_EXC_FMISS_DATA, TLBC_EXC_DMISS_DATA, TLBC_EXC_PROT_READ,
        TLBC_EXC_PROT_WRITE, TLBC_EXC_MISAL_DATA, TLBC_EXC_SUPER_DATA};
      d = (c == TLBC_EXC_BREAK) ? dprev : d;
      dprev = d;
      a = 32'h8000_0003 + (i << 12);
      exp_page = (fmiss || prot) ? {10'h0, a[31:12], 2'h0} : exp_page;
      acc(1'b1, TLBC_SEL_MISC, 32'h0, q);
      tlbc_exc_model_inst.raise(c, 1'b0, d, a);
      acc(1'b0, TLBC_SEL_MISC, 32'h0, q);
      `CHK(q[0], d)
      if (c != TLBC_EXC_BREAK) `CHK(q[3:1], {dmiss, bad, prot})
      `CHK(q[TLBC_WE_BIT], prot || fmiss || dmiss)
      acc(1'b0, TLBC_SEL_FAULT, 32'h0, q);
      `CHK(q, a)
      acc(1'b0, TLBC_SEL_PAGE, 32'h0, q);
      `CHK(q, exp_page)
    end
    $display("test exception causes done");
    acc(1'b1, TLBC_SEL_MISC, 32'h0, q);
    tlbc_exc_model_inst.raise(TLBC_EXC_FMISS_DATA, 1'b1, 1'b1, 32'h1234_5678);
    acc(1'b0, TLBC_SEL_MISC, 32'h0, q);
    `CHK(q, 32'h0000_0001)
    acc(1'b0, TLBC_SEL_PAGE, 32'h0, q);
    `CHK(q, exp_page)
    acc(1'b1, TLBC_SEL_FAULT, 32'hffff_ffff, q);
    acc(1'b0, TLBC_SEL_FAULT, 32'h0, q);
    `CHK(q, 32'h1234_5678)
    $display("test nested exception done");
    print_verdict();
  end
endmodule
